// ### hdl/see_pkg.sv
// Purpose: Shared constants and types for the serial EEPROM link and both of its ends.
// Assumes: clk_sys at 125 MHz; the link clock is made by the host end.
// Notes:   Start and stop bus conditions travel as qualified link strobes.
// What this block does
// - Read starts like write, direction bit one
// - After a read, pointer holds last accessed address plus one
// - Matching read control: ack, then shift byte
// - Master nack plus stop ends device driving
// - Random read: address write, then repeated start
// - Read control resent; cmd_len bytes, last nacked, stop
// - Select bits carry address bits 12 to 14
// - Master ack after byte requests next byte
// - Pointer increments after each completed byte
// - Read pointer runs past top, never wraps zero
// - Eight page cache loads until stop
// - Each loaded page costs one full 5ms
// - Over sixty-four bytes wraps to page zero
// - Busy write cycle ignores every command
// - Aligned start writes bytes consecutively, across blocks
// - Cache pages go to consecutive array pages
// - First byte lands page zero, low bits
// - Trailing bytes fill empty leading page-zero bytes
// - Stop programs page zero at start page
// - Only loaded byte positions get programmed
// - Control byte: type, select, direction bit
// - Address sent as two bytes, top zero
// - Cache load increments only six pointer bits
package see_pkg;
   // ===========================================================
   // Timing
   localparam int CLK_PERIOD_NS   = 8;
   localparam int PAGE_WR_TIME_US = 5000;
   // Longest time, so the integer division rounds down
   localparam int PAGE_WR_CYC     = PAGE_WR_TIME_US * 1000 / CLK_PERIOD_NS;
   localparam int SCL_HALF_CYC    = 4;
   // ===========================================================
   // Geometry and codes
   localparam int         ARRAY_WORDS   = 4096;
   localparam int         CACHE_BYTES   = 64;
   localparam int         PTR_W         = 16;
   localparam logic [7:0] UNUSED_READ   = 8'hFF;
   // Arbitrary value; the real type code is supplied by parameter
   localparam logic [3:0] TYPE_DEFAULT  = 4'h5;
   localparam logic [3:0] ADDR_TOP_ZERO = 4'h0;
   // ===========================================================
   // State types
   typedef enum logic [2:0] {
      L_IDLE  = 3'b000,
      L_CTRL  = 3'b001,
      L_ADRH  = 3'b010,
      L_ADRL  = 3'b011,
      L_WDATA = 3'b100,
      L_RDATA = 3'b101
   } see_link_e;
   typedef enum logic [1:0] {
      P_IDLE = 2'b00,
      P_PROG = 2'b01,
      P_WAIT = 2'b10
   } see_prog_e;
   typedef enum logic [3:0] {
      H_IDLE   = 4'b0000,
      H_START  = 4'b0001,
      H_CTRL   = 4'b0010,
      H_ADRH   = 4'b0011,
      H_ADRL   = 4'b0100,
      H_WDATA  = 4'b0101,
      H_RSTART = 4'b0110,
      H_CTRLR  = 4'b0111,
      H_RDATA  = 4'b1000,
      H_STOP   = 4'b1001
   } see_host_e;
endpackage

// ### hdl/see_if.sv
// Purpose: Two-wire link between host end and device end.
// Assumes: Open-drain data line with pull-up; enable high pulls low.
// Notes:   Start/stop are strobes sampled on a rising link clock edge.
interface see_if;
   logic scl;         // Link clock, made by the host
   logic cond_start;  // Start condition strobe
   logic cond_stop;   // Stop condition strobe
   logic m_sda_out;   // Host data out
   logic m_sda_oe;    // Host pulls data line
   logic d_sda_out;   // Device data out
   logic d_sda_oe;    // Device pulls data line
   logic sda;         // Resolved data line
   assign sda = ~((m_sda_oe & ~m_sda_out) | (d_sda_oe & ~d_sda_out));
   modport host (output scl, cond_start, cond_stop, m_sda_out, m_sda_oe, input sda);
   modport dev  (input scl, cond_start, cond_stop, sda, output d_sda_out, d_sda_oe);
endinterface

// ### hdl/see_sync.sv
// Purpose: Two flip-flop synchroniser for levels.
// Assumes: Input is a level or a toggle that holds for several cycles.
// Notes:   Only the second stage may be read.
module see_sync #(
   parameter int W = 1
) (
   input  wire logic         clk,    // Destination clock
   input  wire logic         rst_b,  // Async reset, active low
   input  wire logic [W-1:0] d,      // Foreign level
   output logic      [W-1:0] q       // Synchronised level
);
   logic [W-1:0] meta;
   always_ff @(posedge clk or negedge rst_b) begin
      if (!rst_b) begin
         meta <= '0;
         q    <= '0;
      end else begin
         meta <= d;
         q    <= meta;
      end
   end
endmodule

// ### hdl/see_dev.sv
// Purpose: Device end: byte engine on the link clock, write programmer on clk_sys.
// Assumes: Host keeps the link strobes and bit timing; chip selects are static.
// Notes:   The array is written only on clk_sys while the link side is blocked.
module see_dev
   import see_pkg::*;
#(
   parameter logic [3:0] TYPE_CODE = TYPE_DEFAULT,  // Arbitrary default
   parameter int         PAGE_CYC  = PAGE_WR_CYC
) (
   see_if.dev         link,                 // Two-wire link
   input  wire logic  clk_sys,              // System clock
   input  wire logic  rst_b,                // Async reset, active low
   input  wire logic  chip_select_pin_lsb,  // Chip select strap bit 0
   input  wire logic  chip_select_pin_mid,  // Chip select strap bit 1
   input  wire logic  chip_select_pin_msb,  // Chip select strap bit 2
   output logic       wr_busy               // Internal write cycle running
);
   localparam int TW = $clog2(PAGE_CYC + 1);

   // ===========================================================
   // Storage
   logic [7:0]       mem   [ARRAY_WORDS];
   logic [7:0]       cache [CACHE_BYTES];
   logic [63:0]      cvalid;

   // ===========================================================
   // Link domain state
   see_link_e        lst;
   logic [3:0]       bcnt;
   logic [7:0]       rsh;
   logic [7:0]       tsh;
   logic             ack_want;
   logic [PTR_W-1:0] ptr;
   logic [PTR_W-1:0] wstart;
   logic [5:0]       cpos;
   logic [6:0]       nbytes;
   logic             launch_tg;
   logic             pend;
   logic             sda_oe;
   logic [2:0]       csel;
   logic             busy_s;
   logic             match;
   logic             cache_we;

   // ===========================================================
   // System domain state
   see_prog_e        pst;
   logic [2:0]       pg;
   logic [2:0]       by;
   logic [TW-1:0]    tmr;
   logic             launch_s;
   logic             launch_d;
   logic             go;
   logic [5:0]       cidx;
   logic [11:0]      aidx;

   see_sync #(.W(3)) u_cs (
      .clk   (link.scl),
      .rst_b (rst_b),
      .d     ({chip_select_pin_msb, chip_select_pin_mid, chip_select_pin_lsb}),
      .q     (csel)
   );
   see_sync #(.W(1)) u_busy (
      .clk   (link.scl),
      .rst_b (rst_b),
      .d     (wr_busy),
      .q     (busy_s)
   );
   see_sync #(.W(1)) u_launch (
      .clk   (clk_sys),
      .rst_b (rst_b),
      .d     (launch_tg),
      .q     (launch_s)
   );

   // Beyond the array the pointer reads filler
   function automatic logic [7:0] rd_byte(input logic [PTR_W-1:0] a);
      if (a < PTR_W'(ARRAY_WORDS)) begin
         rd_byte = mem[a[11:0]];
      end else begin
         rd_byte = UNUSED_READ;
      end
   endfunction

   // Byte in flight is {rsh[6:0], sda} while bcnt is 7
   assign match = (rsh[6:3] == TYPE_CODE) && (rsh[2:0] == csel)
                  && !(pend || busy_s);
   assign cache_we = (lst == L_WDATA) && (bcnt == 4'h8)
                     && !link.cond_start && !link.cond_stop;

   // ===========================================================
   // Link byte engine, rising link clock
   always_ff @(posedge link.scl or negedge rst_b) begin
      if (!rst_b) begin
         lst       <= L_IDLE;
         bcnt      <= 4'h0;
         rsh       <= 8'h00;
         tsh       <= 8'h00;
         ack_want  <= 1'b0;
         ptr       <= '0;
         wstart    <= '0;
         cpos      <= 6'h00;
         nbytes    <= 7'h00;
         cvalid    <= '0;
         launch_tg <= 1'b0;
         pend      <= 1'b0;
      end else begin
         if (busy_s) begin
            pend <= 1'b0;
         end
         if (link.cond_start) begin
            // A repeated start abandons a write; the pointer is already set
            lst      <= L_CTRL;
            bcnt     <= 4'h0;
            ack_want <= 1'b0;
         end else if (link.cond_stop) begin
            if (lst == L_WDATA && nbytes != 7'h00) begin
               launch_tg <= ~launch_tg;
               pend      <= 1'b1;
            end
            lst      <= L_IDLE;
            bcnt     <= 4'h0;
            ack_want <= 1'b0;
         end else if (lst != L_IDLE) begin
            if (bcnt != 4'h8) begin
               rsh  <= {rsh[6:0], link.sda};
               bcnt <= bcnt + 4'h1;
               if (bcnt == 4'h7) begin
                  if (lst == L_CTRL) begin
                     ack_want <= match;
                  end else begin
                     ack_want <= (lst != L_RDATA);
                  end
               end
            end else begin
               bcnt     <= 4'h0;
               ack_want <= 1'b0;
               case (lst)
                  L_CTRL: begin
                     if (!ack_want) begin
                        lst <= L_IDLE;
                     end else if (rsh[0]) begin
                        lst <= L_RDATA;
                        tsh <= rd_byte(ptr);
                     end else begin
                        lst <= L_ADRH;
                     end
                  end
                  L_ADRH: begin
                     ptr[15:8] <= rsh;
                     lst       <= L_ADRL;
                  end
                  L_ADRL: begin
                     ptr[7:0] <= rsh;
                     wstart   <= {ptr[15:8], rsh};
                     cpos     <= {3'h0, rsh[2:0]};
                     nbytes   <= 7'h00;
                     cvalid   <= '0;
                     lst      <= L_WDATA;
                  end
                  L_WDATA: begin
                     cvalid[cpos] <= 1'b1;
                     cpos         <= cpos + 6'h01;
                     ptr[5:0]     <= ptr[5:0] + 6'h01;
                     if (nbytes != 7'(CACHE_BYTES)) begin
                        nbytes <= nbytes + 7'h01;
                     end
                  end
                  L_RDATA: begin
                     // No wrap: the counter runs on into unused space
                     ptr <= ptr + PTR_W'(1);
                     if (!link.sda) begin
                        tsh <= rd_byte(ptr + PTR_W'(1));
                     end else begin
                        lst <= L_IDLE;
                     end
                  end
                  default: lst <= L_IDLE;
               endcase
            end
         end
      end
   end

   always_ff @(posedge link.scl) begin
      if (cache_we) begin
         cache[cpos] <= rsh;
      end
   end

   // ===========================================================
   // Data line, falling link clock so it settles before the rise
   always_ff @(negedge link.scl or negedge rst_b) begin
      if (!rst_b) begin
         sda_oe <= 1'b0;
      end else begin
         sda_oe <= (lst == L_RDATA && bcnt != 4'h8 && !tsh[~bcnt[2:0]])
                   || (bcnt == 4'h8 && ack_want);
      end
   end
   assign link.d_sda_oe  = sda_oe;
   assign link.d_sda_out = 1'b0;

   // ===========================================================
   // Write programmer, system clock
   assign go   = launch_s ^ launch_d;
   assign cidx = {pg, by};
   // Cache page n goes to the n-th page after the start page
   assign aidx = {9'(wstart[11:3] + {6'h00, pg}), by};

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         launch_d <= 1'b0;
      end else begin
         launch_d <= launch_s;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         pst     <= P_IDLE;
         pg      <= 3'h0;
         by      <= 3'h0;
         tmr     <= '0;
         wr_busy <= 1'b0;
      end else begin
         case (pst)
            P_IDLE: begin
               if (go) begin
                  pst     <= P_PROG;
                  pg      <= 3'h0;
                  by      <= 3'h0;
                  wr_busy <= 1'b1;
               end
            end
            P_PROG: begin
               by <= by + 3'h1;
               if (by == 3'h7) begin
                  pst <= P_WAIT;
                  tmr <= TW'(PAGE_CYC - 1);
               end
            end
            P_WAIT: begin
               // A part-filled page still waits the full page time
               if (tmr != '0) begin
                  tmr <= tmr - TW'(1);
               end else if (pg != 3'h7 && cvalid[{pg + 3'h1, 3'h0} +: 8] != 8'h00) begin
                  pg  <= pg + 3'h1;
                  pst <= P_PROG;
               end else begin
                  pst     <= P_IDLE;
                  wr_busy <= 1'b0;
               end
            end
            default: pst <= P_IDLE;
         endcase
      end
   end

   always_ff @(posedge clk_sys) begin
      if (pst == P_PROG && cvalid[cidx]) begin
         mem[aidx] <= cache[cidx];
      end
   end
endmodule

// ### hdl/see_host.sv
// Purpose: Host end: runs whole write and read frames on the link.
// Assumes: wr_data is valid in the cycle before wr_take is high.
// Notes:   The link clock idles low and only toggles inside a frame.
module see_host
   import see_pkg::*;
#(
   parameter logic [3:0] TYPE_CODE = TYPE_DEFAULT,  // Arbitrary default
   parameter int         HALF      = SCL_HALF_CYC
) (
   see_if.host              link,       // Two-wire link
   input  wire logic        clk_sys,    // System clock
   input  wire logic        rst_b,      // Async reset, active low
   input  wire logic        cmd_valid,  // Command request
   input  wire logic        cmd_read,   // 1 read, 0 write
   input  wire logic        cmd_random, // Read: set address first
   input  wire logic [15:0] cmd_addr,   // Bits 14:12 pick the chip
   input  wire logic [6:0]  cmd_len,    // Data bytes
   output logic             cmd_ready,  // Idle, command taken
   input  wire logic [7:0]  wr_data,    // Write byte
   output logic             wr_take,    // Write byte consumed
   output logic [7:0]       rd_data,    // Read byte
   output logic             rd_valid,   // Read byte pulse
   output logic             done,       // Frame finished pulse
   output logic             nack        // Last frame refused
);
   see_host_e  hst;
   logic [$clog2(HALF)-1:0] hcnt;
   logic       scl;
   logic       tick;
   logic       sda_s;
   logic       oe;
   logic       c_start;
   logic       c_stop;
   logic [3:0] hb;
   logic [7:0] tx;
   logic [7:0] rx;
   logic [6:0] left;
   logic [15:0] addr;
   logic       rd;
   logic       rnd;

   see_sync #(.W(1)) u_sda (.clk(clk_sys), .rst_b(rst_b), .d(link.sda), .q(sda_s));

   assign tick = scl && (hcnt == ($clog2(HALF))'(HALF - 1));
   assign link.scl        = scl;
   assign link.cond_start = c_start;
   assign link.cond_stop  = c_stop;
   assign link.m_sda_oe   = oe;
   assign link.m_sda_out  = 1'b0;

   // ===========================================================
   // Link clock divider
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hcnt <= '0;
         scl  <= 1'b0;
      end else if (hst == H_IDLE) begin
         hcnt <= '0;
         scl  <= 1'b0;
      end else if (hcnt == ($clog2(HALF))'(HALF - 1)) begin
         hcnt <= '0;
         scl  <= ~scl;
      end else begin
         hcnt <= hcnt + 1'b1;
      end
   end

   // ===========================================================
   // Frame sequencer; each tick ends one link clock slot
   always_ff @(posedge clk_sys or negedge rst_b) begin
      if (!rst_b) begin
         hst <= H_IDLE;
         {oe, c_start, c_stop, wr_take, rd_valid, done, nack, rd, rnd} <= '0;
         cmd_ready <= 1'b1;
         hb <= 4'h0;
         tx <= 8'h00;
         rx <= 8'h00;
         rd_data <= 8'h00;
         left <= 7'h00;
         addr <= 16'h0000;
      end else begin
         wr_take  <= 1'b0;
         rd_valid <= 1'b0;
         done     <= 1'b0;
         if (hst == H_IDLE) begin
            if (cmd_valid) begin
               hst       <= H_START;
               c_start   <= 1'b1;
               cmd_ready <= 1'b0;
               nack      <= 1'b0;
               addr      <= cmd_addr;
               rd        <= cmd_read;
               rnd       <= cmd_random;
               left      <= cmd_len;
            end
         end else if (tick) begin
            c_start <= 1'b0;
            c_stop  <= 1'b0;
            if (hst == H_START || hst == H_RSTART) begin
               // Select bits double as address bits 12 to 14
               tx  <= {TYPE_CODE, addr[14:12], hst == H_RSTART || (rd && !rnd)};
               oe  <= ~TYPE_CODE[3];
               hb  <= 4'h0;
               hst <= (hst == H_START) ? H_CTRL : H_CTRLR;
            end else if (hst == H_STOP) begin
               oe        <= 1'b0;
               hst       <= H_IDLE;
               done      <= 1'b1;
               cmd_ready <= 1'b1;
            end else if (hst == H_RDATA) begin
               if (hb != 4'h8) begin
                  rx <= {rx[6:0], sda_s};
                  hb <= hb + 4'h1;
                  oe <= 1'b0;
                  if (hb == 4'h7) begin
                     rd_data  <= {rx[6:0], sda_s};
                     rd_valid <= 1'b1;
                     oe       <= (left > 7'h01);
                  end
               end else begin
                  oe   <= 1'b0;
                  hb   <= 4'h0;
                  left <= left - 7'h01;
                  if (left == 7'h01) begin
                     hst    <= H_STOP;
                     c_stop <= 1'b1;
                  end
               end
            end else if (hb != 4'h8) begin
               hb <= hb + 4'h1;
               tx <= {tx[6:0], 1'b0};
               oe <= (hb != 4'h7) && !tx[6];
            end else if (sda_s) begin
               nack   <= 1'b1;
               oe     <= 1'b0;
               hst    <= H_STOP;
               c_stop <= 1'b1;
            end else begin
               hb <= 4'h0;
               oe <= 1'b0;
               case (hst)
                  H_CTRL: begin
                     if (rd && !rnd) begin
                        hst <= H_RDATA;
                     end else begin
                        hst <= H_ADRH;
                        tx  <= {ADDR_TOP_ZERO, addr[11:8]};
                        oe  <= 1'b1;
                     end
                  end
                  H_ADRH: begin
                     hst <= H_ADRL;
                     tx  <= addr[7:0];
                     oe  <= ~addr[7];
                  end
                  H_CTRLR: hst <= H_RDATA;
                  default: begin
                     if (hst == H_ADRL && rd) begin
                        hst     <= H_RSTART;
                        c_start <= 1'b1;
                     end else if (left == 7'h00) begin
                        hst    <= H_STOP;
                        c_stop <= 1'b1;
                     end else begin
                        hst     <= H_WDATA;
                        tx      <= wr_data;
                        oe      <= ~wr_data[7];
                        wr_take <= 1'b1;
                        left    <= left - 7'h01;
                     end
                  end
               endcase
            end
         end
      end
   end
endmodule

// ### bench/see_chk_sva.sv
// Purpose: Assertions on the two-wire link between the host and device ends.
// Assumes: Host half period of four clk_sys cycles.
// Notes:   Start and stop are strobes, so sda edges are not checked.
module see_chk (
   input wire logic clk_sys,     // System clock
   input wire logic rst_b,       // Async reset, active low
   input wire logic scl,         // Link clock
   input wire logic cond_start,  // Start strobe
   input wire logic cond_stop,   // Stop strobe
   input wire logic m_sda_oe,    // Host pull
   input wire logic d_sda_oe     // Device pull
);
   timeunit 1ns;
   timeprecision 1ps;
   // ===========================================================
   // Link timing
   scl_high_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $rose(scl) |-> scl [*4] ##1 !scl) else $error("scl high phase wrong");
   start_slot_a: assert property (@(posedge scl) disable iff (!rst_b)
      cond_start |=> !cond_start) else $error("start longer than a slot");
   stop_slot_a: assert property (@(posedge scl) disable iff (!rst_b)
      cond_stop |=> !cond_stop) else $error("stop longer than a slot");
   no_clash_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      !(cond_start && cond_stop)) else $error("start and stop together");
   // ===========================================================
   // Data line ownership
   dev_quiet_start_a: assert property (@(posedge scl) disable iff (!rst_b)
      cond_start |-> !d_sda_oe) else $error("device pulls at start");
   dev_quiet_stop_a: assert property (@(posedge scl) disable iff (!rst_b)
      cond_stop |-> !d_sda_oe) else $error("device pulls at stop");
   dev_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(d_sda_oe) |-> !scl) else $error("device data moved with scl high");
   host_edge_a: assert property (@(posedge clk_sys) disable iff (!rst_b)
      $changed(m_sda_oe) |-> !scl) else $error("host data moved with scl high");
   cover property (@(posedge scl) disable iff (!rst_b) cond_start);
   cover property (@(posedge scl) disable iff (!rst_b) cond_stop);
   cover property (@(posedge clk_sys) disable iff (!rst_b) $rose(d_sda_oe));
endmodule

// ### bench/tb_top.sv
// Purpose: Self-checking bench joining host and device ends over the link.
// Assumes: Device strapped as chip 2; short page write time.
// Notes:   A byte model of the array predicts every read.
module tb_top import see_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk_sys = 1'b0, rst_b = 1'b0;
   logic        cmd_valid = 1'b0, cmd_read = 1'b0, cmd_random = 1'b0;
   logic [15:0] cmd_addr = 16'h0000;
   logic [6:0]  cmd_len = 7'h00;
   logic [7:0]  wr_data, rd_data;
   logic        cmd_ready, wr_take, rd_valid, done, nack, wr_busy;
   logic [7:0]  mem [4096];
   logic [7:0]  wbuf [128];
   logic [7:0]  rq [$];
   logic [15:0] ptr;
   int          widx = 0, n_mismatch = 0, compares = 0, cyc = 0, seed = 54449;
   see_if       i_see_if ();
   assign wr_data = wbuf[widx];
   always #4 clk_sys = ~clk_sys;
   see_host i_see_host (.link(i_see_if), .clk_sys, .rst_b, .cmd_valid, .cmd_read,
      .cmd_random, .cmd_addr, .cmd_len, .cmd_ready, .wr_data, .wr_take, .rd_data,
      .rd_valid, .done, .nack);
   // Page time kept long enough that the first poll always lands in the write cycle
   see_dev #(.PAGE_CYC(300)) i_see_dev (.link(i_see_if), .clk_sys, .rst_b,
      .chip_select_pin_lsb(1'b0), .chip_select_pin_mid(1'b1), .chip_select_pin_msb(1'b0),
      .wr_busy);
   see_chk i_see_chk (.clk_sys, .rst_b, .scl(i_see_if.scl), .cond_start(i_see_if.cond_start),
      .cond_stop(i_see_if.cond_stop), .m_sda_oe(i_see_if.m_sda_oe),
      .d_sda_oe(i_see_if.d_sda_oe));
   // ===========================================================
   // Expectation functions
   // Array address that write byte i lands on, cache wrap included
   function automatic logic [11:0] cache_addr(input logic [11:0] a, input int i);
      int p;
      p = (a[2:0] + i) % 64;
      return 12'((a[11:3] + p / 8) * 8 + p % 8);
   endfunction
   // Past the array the pointer reads the filler value
   function automatic logic [7:0] exp_byte(input logic [15:0] q);
      return (q >= 16'h1000) ? 8'hFF : mem[q[11:0]];
   endfunction
   // ===========================================================
   // Tasks
   task automatic give_verdict();
      $display("compares=%0d n_mismatch=%0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic chk_byte(input logic [7:0] g, input logic [7:0] e);
      compares++;
      if (g !== e) begin
         n_mismatch++;
         $display("[FAIL] %0t got %h exp %h", $time, g, e);
      end
   endtask
   task automatic chk_bit(input logic g, input logic e);
      chk_byte({7'h00, g}, {7'h00, e});
   endtask
   task automatic run(input logic r, input logic rnd, input logic [15:0] a, input logic [6:0] n);
      @(posedge clk_sys);
      cmd_valid <= 1'b1;
      cmd_read <= r;
      cmd_random <= rnd;
      cmd_addr <= a;
      cmd_len <= n;
      do @(posedge clk_sys); while (cmd_ready !== 1'b1);
      cmd_valid <= 1'b0;
      do @(posedge clk_sys); while (done !== 1'b1);
   endtask
   task automatic wr(input logic [11:0] a, input int n);
      int k;
      for (int i = 0; i < n; i++) begin
         wbuf[i] = 8'($random(seed));
         mem[cache_addr(a, i)] = wbuf[i];
      end
      widx <= 0;
      run(1'b0, 1'b0, {4'h2, a}, 7'(n));
      run(1'b0, 1'b0, {4'h2, a}, 7'h00);
      chk_bit(nack, 1'b1);
      chk_bit(wr_busy, 1'b1);
      for (k = 0; k < 40 && nack !== 1'b0; k++) run(1'b0, 1'b0, {4'h2, a}, 7'h00);
      chk_bit(nack, 1'b0);
      ptr = {4'h0, a};
   endtask
   task automatic rd(input logic rnd, input logic [11:0] a, input int n);
      rq.delete();
      if (rnd) ptr = {4'h0, a};
      run(1'b1, rnd, {4'h2, a}, 7'(n));
      for (int i = 0; i < n; i++) begin
         chk_byte(rq[i], exp_byte(ptr));
         ptr++;
      end
   endtask
   // ===========================================================
   // Run
   always @(posedge clk_sys) begin
      cyc <= cyc + 1;
      if (wr_take === 1'b1) widx <= widx + 1;
      if (rd_valid === 1'b1) rq.push_back(rd_data);
      if (cyc == 100000) begin
         n_mismatch++;
         give_verdict();
      end
   end
   initial begin
      logic [11:0] a;
      int          n;
      repeat (2) @(posedge clk_sys);
      rst_b <= 1'b1;
      a = 12'($random(seed));
      wr(a, 6);
      rd(1'b1, a, 5);
      rd(1'b0, a, 1);
      for (int j = 0; j < 2; j++) begin
         a = 12'($random(seed));
         n = 1 + $unsigned($random(seed)) % 40;
         wr(a, n);
         rd(1'b1, a, n);
      end
      wr(12'h7E0, 66);
      rd(1'b1, 12'h7E0, 64);
      wr(12'h01A, 64);
      rd(1'b1, 12'h018, 64);
      wr(12'hFF8, 8);
      rd(1'b1, 12'hFFC, 6);
      rd(1'b0, 12'h000, 1);
      run(1'b1, 1'b0, 16'h0000, 7'h01);
      chk_bit(nack, 1'b1);
      give_verdict();
   end
endmodule
